// [rtl/gpx_pkg.sv]
// shared constants and types for the dual general-purpose port block
// assumes an 8-bit register port with byte offsets and one 200 MHz clock
package gpx_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] GPX_OFS_A_DATA = 8'h00;
  localparam logic [7:0] GPX_OFS_B_DATA = 8'h01;
  localparam logic [7:0] GPX_OFS_A_DIR  = 8'h04;
  localparam logic [7:0] GPX_OFS_B_DIR  = 8'h05;
  localparam logic [7:0] GPX_OFS_A_PUE  = 8'h0b;
  localparam logic [7:0] GPX_OFS_B_PUE  = 8'h0c;

  // ---------------------------------------------------------------
  // field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int         GPX_A_PINS       = 6;
  localparam int         GPX_B_PINS       = 8;
  localparam int         GPX_BIT_AWAKE    = 6;
  localparam int         GPX_BIT_IN_ONLY  = 2;
  localparam int         GPX_BIT_OSC_PIN  = 4;
  localparam int         GPX_BIT_OSC_SEL  = 7;
  localparam logic [5:0] GPX_A_DIR_MASK   = 6'h3b;
  localparam logic [5:0] GPX_A_DIR_RST    = 6'h00;
  localparam logic [7:0] GPX_B_DIR_RST    = 8'h00;
  localparam logic [5:0] GPX_A_PUE_RST    = 6'h00;
  localparam logic [7:0] GPX_B_PUE_RST    = 8'h00;
  localparam logic       GPX_OSC_SEL_RST  = 1'b0;
  localparam logic [7:0] GPX_RDATA_RST    = 8'h00;
  localparam int         GPX_SYNC_STAGES  = 2;

  // ---------------------------------------------------------------
  // state carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0] dir_a;
    logic [7:0] dir_b;
    logic [5:0] pue_a;
    logic       osc_sel;
    logic [7:0] pue_b;
    logic [7:0] rdata;
  } gpx_regs_t;

  typedef struct packed {
    logic [5:0] lat_a;
    logic [7:0] lat_b;
  } gpx_latch_t;

endpackage

// [rtl/gpx_sync.sv]
// two-stage synchroniser for a group of pin levels
// assumes asynchronous pin inputs and the system clock
`timescale 1ns/1ps
module gpx_sync
  import gpx_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage only feeds the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule

// [rtl/gpx_pad.sv]
// per-pin pad control: driver enable, pull-up and read-back select
// assumes synchronised pin levels and registered control bits
`timescale 1ns/1ps
module gpx_pad
  import gpx_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic [W-1:0] i_dir,
  input  wire logic [W-1:0] i_latch,
  input  wire logic [W-1:0] i_pue,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_oe,
  output logic      [W-1:0] o_pu,
  output logic      [W-1:0] o_rd
);

  // driver on for outputs, pull-up only on enabled inputs
  assign o_oe = i_dir;
  assign o_pu = i_pue & ~i_dir;
  // outputs read their latch, inputs read the pin
  assign o_rd = (i_dir & i_latch) | (~i_dir & i_pin);

endmodule

// [rtl/gpx_top.sv]
// dual general-purpose port: six-pin special port and eight-pin port
// assumes a one-cycle strobe register port, pins from outside the clock
// domain, and keyboard, wake-up and oscillator logic outside this block
`timescale 1ns/1ps

// Operation
// - eight-pin bidirectional port beside six-pin port
// - pin two never gets an output driver
// - interrupt pin enabled: data bit two reads 0
// - interrupt pin disabled: branch level reads 1
// - six-pin data latches untouched by reset
// - data bit six shows wake-up latch
// - enabled pins feed keyboard interrupt inputs, except pin four while it drives the fast clock
// - six-pin direction 1 drives, 0 inputs
// - reset clears six-pin direction bits
// - six-pin read: latch if output, else pin
// - latch writes always land, inputs unaffected
// - pull-up only when enabled and input
// - pull-up enable 0 disconnects pull-up
// - select bit drives fast clock on pin
// - select bit ignored with crystal oscillator
// - eight-pin data latches untouched by reset
// - eight-pin direction per matching bit
// - eight-pin direction 1 drives, 0 inputs
// - reset clears eight-pin direction bits
// - eight-pin read: latch if output, else pin
// - eight-pin pull-up only while input
module gpx_top
  import gpx_pkg::*;
(
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RESETN,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  input  wire logic [5:0] I_A_PIN,
  output logic      [5:0] O_A_OUT,
  output logic      [5:0] O_A_OE,
  output logic      [5:0] O_A_PU,
  input  wire logic [7:0] I_B_PIN,
  output logic      [7:0] O_B_OUT,
  output logic      [7:0] O_B_OE,
  output logic      [7:0] O_B_PU,
  input  wire logic       I_IRQ_PIN_EN,
  input  wire logic       I_OSC_INTERNAL,
  input  wire logic       I_CLK_X4,
  input  wire logic       I_AWAKE_LATCH,
  input  wire logic [5:0] I_KBI_EN,
  output logic      [5:0] O_KBI_PIN,
  output logic            O_IRQ_LEVEL
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  gpx_regs_t  st_reg;
  gpx_regs_t  st_next;
  gpx_latch_t lat_reg;
  gpx_latch_t lat_next;
  logic [5:0] pin_a_s;
  logic [7:0] pin_b_s;
  logic [5:0] a_oe_raw;
  logic [5:0] a_pu_raw;
  logic [5:0] a_rd;
  logic [7:0] b_rd;
  logic [7:0] a_view;
  logic       osc_out_on;
  logic       wr_a_data;
  logic       wr_b_data;
  logic       wr_a_dir;
  logic       wr_b_dir;
  logic       wr_a_pue;
  logic       wr_b_pue;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  gpx_sync #(.W(GPX_A_PINS)) u_sync_a (
    .i_clk    (I_SYS_CLK),
    .i_resetn (I_RESETN),
    .i_async  (I_A_PIN),
    .o_sync   (pin_a_s)
  );

  gpx_sync #(.W(GPX_B_PINS)) u_sync_b (
    .i_clk    (I_SYS_CLK),
    .i_resetn (I_RESETN),
    .i_async  (I_B_PIN),
    .o_sync   (pin_b_s)
  );

  // -----------------------------------------------------------------
  // pad control for both ports
  // -----------------------------------------------------------------
  // six-pin read select
  gpx_pad #(.W(GPX_A_PINS)) u_pad_a (
    .i_dir   (st_reg.dir_a),
    .i_latch (lat_reg.lat_a),
    .i_pue   (st_reg.pue_a),
    .i_pin   (pin_a_s),
    .o_oe    (a_oe_raw),
    .o_pu    (a_pu_raw),
    .o_rd    (a_rd)
  );

  gpx_pad #(.W(GPX_B_PINS)) u_pad_b (
    .i_dir   (st_reg.dir_b),
    .i_latch (lat_reg.lat_b),
    .i_pue   (st_reg.pue_b),
    .i_pin   (pin_b_s),
    .o_oe    (O_B_OE),
    .o_pu    (O_B_PU),
    .o_rd    (b_rd)
  );

  // -----------------------------------------------------------------
  // register decode
  // -----------------------------------------------------------------
  // one strobe per register
  always_comb begin
    wr_a_data = 1'b0;
    wr_b_data = 1'b0;
    wr_a_dir  = 1'b0;
    wr_b_dir  = 1'b0;
    wr_a_pue  = 1'b0;
    wr_b_pue  = 1'b0;
    if (I_WR && I_ADDR == GPX_OFS_A_DATA) begin
      wr_a_data = 1'b1;
    end else if (I_WR && I_ADDR == GPX_OFS_B_DATA) begin
      wr_b_data = 1'b1;
    end else if (I_WR && I_ADDR == GPX_OFS_A_DIR) begin
      wr_a_dir = 1'b1;
    end else if (I_WR && I_ADDR == GPX_OFS_B_DIR) begin
      wr_b_dir = 1'b1;
    end else if (I_WR && I_ADDR == GPX_OFS_A_PUE) begin
      wr_a_pue = 1'b1;
    end else if (I_WR && I_ADDR == GPX_OFS_B_PUE) begin
      wr_b_pue = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // six-pin data view
  // -----------------------------------------------------------------
  // assembles the readable six-pin data byte
  always_comb begin
    a_view = {2'b00, a_rd};
    a_view[GPX_BIT_AWAKE] = I_AWAKE_LATCH;
    if (I_IRQ_PIN_EN) begin
      a_view[GPX_BIT_IN_ONLY] = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  // registers, read data and data latches
  always_comb begin
    st_next  = st_reg;
    lat_next = lat_reg;
    if (wr_a_data) begin
      lat_next.lat_a = I_WDATA[5:0];
    end
    if (wr_b_data) begin
      lat_next.lat_b = I_WDATA;
    end
    if (wr_a_dir) begin
      st_next.dir_a = I_WDATA[5:0] & GPX_A_DIR_MASK;
    end
    if (wr_b_dir) begin
      st_next.dir_b = I_WDATA;
    end
    if (wr_a_pue) begin
      st_next.pue_a   = I_WDATA[5:0];
      st_next.osc_sel = I_WDATA[GPX_BIT_OSC_SEL];
    end
    if (wr_b_pue) begin
      st_next.pue_b = I_WDATA;
    end
    // read data valid only after a read strobe
    st_next.rdata = GPX_RDATA_RST;
    if (I_RD) begin
      if (I_ADDR == GPX_OFS_A_DATA) begin
        st_next.rdata = a_view;
      end else if (I_ADDR == GPX_OFS_B_DATA) begin
        st_next.rdata = b_rd;
      end else if (I_ADDR == GPX_OFS_A_DIR) begin
        st_next.rdata = {2'b00, st_reg.dir_a};
      end else if (I_ADDR == GPX_OFS_B_DIR) begin
        st_next.rdata = st_reg.dir_b;
      end else if (I_ADDR == GPX_OFS_A_PUE) begin
        st_next.rdata = {st_reg.osc_sel, 1'b0, st_reg.pue_a};
      end else if (I_ADDR == GPX_OFS_B_PUE) begin
        st_next.rdata = st_reg.pue_b;
      end
    end
  end

  // -----------------------------------------------------------------
  // state registers
  // -----------------------------------------------------------------
  // directions clear on reset
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_reg.dir_a   <= GPX_A_DIR_RST;
      st_reg.dir_b   <= GPX_B_DIR_RST;
      st_reg.pue_a   <= GPX_A_PUE_RST;
      st_reg.osc_sel <= GPX_OSC_SEL_RST;
      st_reg.pue_b   <= GPX_B_PUE_RST;
      st_reg.rdata   <= GPX_RDATA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // data latches keep value through reset
  always_ff @(posedge I_SYS_CLK) begin
    lat_reg <= lat_next;
  end

  // -----------------------------------------------------------------
  // pin outputs
  // -----------------------------------------------------------------
  // clock out only with internal oscillator
  assign osc_out_on = st_reg.osc_sel & I_OSC_INTERNAL;

  // six-pin drivers, pull-ups and the shared oscillator pin
  always_comb begin
    O_A_OUT = lat_reg.lat_a;
    O_A_OE  = a_oe_raw;
    // pull-up gated by enable and direction
    O_A_PU  = a_pu_raw;
    O_A_OE[GPX_BIT_IN_ONLY] = 1'b0;
    if (osc_out_on) begin
      O_A_OUT[GPX_BIT_OSC_PIN] = I_CLK_X4;
      O_A_OE[GPX_BIT_OSC_PIN]  = 1'b1;
      O_A_PU[GPX_BIT_OSC_PIN]  = 1'b0;
    end
  end

  assign O_B_OUT = lat_reg.lat_b;
  assign O_RDATA = st_reg.rdata;

  // -----------------------------------------------------------------
  // keyboard and interrupt pin levels
  // -----------------------------------------------------------------
  // enabled pins reach keyboard logic, except the oscillator pin while it drives the clock
  always_comb begin
    O_KBI_PIN = pin_a_s & I_KBI_EN;
    if (osc_out_on) begin
      O_KBI_PIN[GPX_BIT_OSC_PIN] = 1'b0;
    end
  end

  // branch level forced high when disabled
  assign O_IRQ_LEVEL = I_IRQ_PIN_EN ? pin_a_s[GPX_BIT_IN_ONLY] : 1'b1;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESETN);

  sequence s_rd_a;
    I_RD && I_ADDR == GPX_OFS_A_DATA;
  endsequence

  sequence s_rd_b;
    I_RD && I_ADDR == GPX_OFS_B_DATA;
  endsequence

  sequence s_wr_b_dir;
    I_WR && I_ADDR == GPX_OFS_B_DIR;
  endsequence

  chk_in_only_pin: assert property (
    !O_A_OE[GPX_BIT_IN_ONLY])
    else $error("input-only pin driven");

  chk_irq_bit_mask: assert property (
    s_rd_a ##0 I_IRQ_PIN_EN |=> !O_RDATA[GPX_BIT_IN_ONLY])
    else $error("bit two not zero with interrupt pin on");

  chk_branch_level: assert property (
    !I_IRQ_PIN_EN |-> O_IRQ_LEVEL)
    else $error("branch level not high when disabled");

  chk_awake_view: assert property (
    s_rd_a |=> O_RDATA[GPX_BIT_AWAKE] == $past(I_AWAKE_LATCH))
    else $error("wake-up bit mismatch");

  chk_kbi_gate: assert property (
    !I_KBI_EN[0] |-> !O_KBI_PIN[0])
    else $error("disabled keyboard pin passed");

  // six-pin read of an output pin
  chk_a_read_sel: assert property (
    s_rd_a ##0 st_reg.dir_a[0] |=> O_RDATA[0] == $past(lat_reg.lat_a[0]))
    else $error("six-pin output read not from latch");

  chk_latch_write: assert property (
    I_WR && I_ADDR == GPX_OFS_B_DATA |=> lat_reg.lat_b == $past(I_WDATA))
    else $error("latch write lost");

  chk_pullup_off: assert property (
    st_reg.dir_a[1] |-> !O_A_PU[1] && O_A_OE[1])
    else $error("pull-up on an output pin");

  chk_pullup_dis: assert property (
    !st_reg.pue_b[3] |-> !O_B_PU[3])
    else $error("pull-up active while disabled");

  chk_osc_ignore: assert property (
    !I_OSC_INTERNAL && !st_reg.dir_a[GPX_BIT_OSC_PIN]
      |-> !O_A_OE[GPX_BIT_OSC_PIN])
    else $error("oscillator pin driven on crystal option");

  // direction write reaches driver next cycle
  chk_b_dir_write: assert property (
    s_wr_b_dir |=> O_B_OE == $past(I_WDATA))
    else $error("eight-pin direction write not applied");

  chk_b_read_sel: assert property (
    s_rd_b ##0 !st_reg.dir_b[5] |=> O_RDATA[5] == $past(pin_b_s[5]))
    else $error("eight-pin input read not from pin");

  chk_b_pullup: assert property (
    O_B_PU[2] |-> !O_B_OE[2] && st_reg.pue_b[2])
    else $error("eight-pin pull-up while output");

  chk_reserved_zero: assert property (
    I_RD && I_ADDR == GPX_OFS_A_DIR |=> O_RDATA[7:6] == 2'b00
      && !O_RDATA[GPX_BIT_IN_ONLY])
    else $error("reserved direction bits not zero");

  chk_dir_reset: assert property (
    $rose(I_RESETN) |-> st_reg.dir_a == GPX_A_DIR_RST
      && st_reg.dir_b == GPX_B_DIR_RST)
    else $error("directions not clear after reset");

endmodule

// [test/gpx_pins.sv]
// board-side pad model for the six-pin and eight-pin ports
// assumes pad controls from gpx_top and board levels from the bench
`timescale 1ns/1ps
module gpx_pins
  import gpx_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [5:0] i_a_out,
  input  wire logic [5:0] i_a_oe,
  input  wire logic [5:0] i_a_pu,
  input  wire logic [5:0] i_a_ext,
  input  wire logic [5:0] i_a_en,
  input  wire logic [7:0] i_b_out,
  input  wire logic [7:0] i_b_oe,
  input  wire logic [7:0] i_b_pu,
  input  wire logic [7:0] i_b_ext,
  input  wire logic [7:0] i_b_en,
  output logic      [5:0] o_a_pin,
  output logic      [7:0] o_b_pin
);
  logic [7:0] float_reg = 8'h55;

  // an undriven, unpulled pin wanders every cycle
  always @(posedge i_clk) begin
    float_reg <= ~float_reg;
  end

  // device driver wins, then pull-up, then board level
  always_comb begin
    o_a_pin = (i_a_oe & i_a_out) | (~i_a_oe & i_a_pu)
            | (~i_a_oe & ~i_a_pu & i_a_en & i_a_ext)
            | (~i_a_oe & ~i_a_pu & ~i_a_en & float_reg[5:0]);
    o_b_pin = (i_b_oe & i_b_out) | (~i_b_oe & i_b_pu)
            | (~i_b_oe & ~i_b_pu & i_b_en & i_b_ext)
            | (~i_b_oe & ~i_b_pu & ~i_b_en & float_reg);
  end
endmodule

// [test/gpx_top_tb_top.sv]
// self-checking bench for the dual general-purpose port block
// assumes gpx_pins as board model and a one-cycle strobe register port
`timescale 1ns/1ps
module gpx_top_tb_top
  import gpx_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic        wr = 1'b0, rd = 1'b0, irq_lvl;
  logic        irq_en = 1'b0, osc_int = 1'b0, clk_x4 = 1'b0, awake = 1'b0;
  logic [5:0]  kbi_en = 6'h00, a_ext = 6'h00, a_en = 6'h00;
  logic [5:0]  a_pin, a_out, a_oe, a_pu, kbi_pin;
  logic [7:0]  b_ext = 8'h00, b_en = 8'h00, b_pin, b_out, b_oe, b_pu;
  logic [7:0]  m_dir_a, m_dir_b, m_pue_a, m_pue_b, m_lat_a, m_lat_b;
  logic        m_sel;
  logic [7:0]  oe_a, pu_a, out_a, mk_a, lv_a, rd_a, rm_a, kb_a, km_a;
  logic [7:0]  pu_b, mk_b, lv_b, rd_b, r;
  logic [31:0] seed = 32'h4c29;
  int          error_cnt = 0;
  int          comparisons = 0;
  logic [7:0]  ofs [7] = '{GPX_OFS_A_DATA, GPX_OFS_B_DATA, GPX_OFS_A_PUE,
                           GPX_OFS_B_PUE, 8'h02, GPX_OFS_A_DIR, GPX_OFS_B_DIR};

  always #2.5 sys_clk = ~sys_clk;

  gpx_top gpx_top_i (
    .I_SYS_CLK(sys_clk), .I_RESETN(resetn), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_A_PIN(a_pin), .O_A_OUT(a_out), .O_A_OE(a_oe), .O_A_PU(a_pu),
    .I_B_PIN(b_pin), .O_B_OUT(b_out), .O_B_OE(b_oe), .O_B_PU(b_pu),
    .I_IRQ_PIN_EN(irq_en), .I_OSC_INTERNAL(osc_int), .I_CLK_X4(clk_x4),
    .I_AWAKE_LATCH(awake), .I_KBI_EN(kbi_en), .O_KBI_PIN(kbi_pin),
    .O_IRQ_LEVEL(irq_lvl));

  gpx_pins gpx_pins_i (
    .i_clk(sys_clk), .i_a_out(a_out), .i_a_oe(a_oe), .i_a_pu(a_pu),
    .i_a_ext(a_ext), .i_a_en(a_en), .i_b_out(b_out), .i_b_oe(b_oe),
    .i_b_pu(b_pu), .i_b_ext(b_ext), .i_b_en(b_en), .o_a_pin(a_pin),
    .o_b_pin(b_pin));

  // ---------------------------------------------------------------
  // bus tasks, model and compares
  // ---------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic cmp(input logic [7:0] got, exp, msk);
    comparisons++;
    if ((got & msk) !== (exp & msk)) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle write, model follows the register map
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    case (a)
      GPX_OFS_A_DATA: m_lat_a = d & 8'h3f;
      GPX_OFS_B_DATA: m_lat_b = d;
      GPX_OFS_A_DIR:  m_dir_a = d & 8'h3b;
      GPX_OFS_B_DIR:  m_dir_b = d;
      GPX_OFS_A_PUE: begin
        m_pue_a = d & 8'h3f;
        m_sel = d[7];
      end
      GPX_OFS_B_PUE:  m_pue_b = d;
      default: ;
    endcase
  endtask

  // read data stand one cycle only, then zero
  task automatic rd_chk(input logic [7:0] a, exp, msk);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 cmp(rdata, exp, msk);
    @(posedge sys_clk);
    #1 cmp(rdata, 8'h00, 8'hff);
  endtask

  // expected pads, pin levels and read-back from the model
  task automatic predict;
    logic ck;
    ck = m_sel & osc_int;
    oe_a = m_dir_a | {3'b000, ck, 4'h0};
    pu_a = m_pue_a & ~oe_a;
    out_a = m_lat_a;
    out_a[4] = ck ? clk_x4 : m_lat_a[4];
    mk_a = (oe_a | pu_a | {2'b00, a_en}) & 8'h3f;
    lv_a = (oe_a & out_a) | (~oe_a & pu_a) | (~oe_a & ~pu_a & {2'b00, a_ext});
    rd_a = (m_dir_a & m_lat_a) | (~m_dir_a & lv_a & 8'h3f);
    rd_a[6] = awake;
    rd_a[2] = lv_a[2] & ~irq_en;
    rm_a = 8'hc0 | m_dir_a | mk_a;
    rm_a[2] = mk_a[2] | irq_en;
    kb_a = lv_a & {2'b00, kbi_en} & ~{3'b000, ck, 4'h0};
    km_a = mk_a | ~{2'b00, kbi_en} | {3'b000, ck, 4'h0};
    pu_b = m_pue_b & ~m_dir_b;
    mk_b = m_dir_b | pu_b | b_en;
    lv_b = (m_dir_b & m_lat_b) | (~m_dir_b & pu_b) | (~m_dir_b & ~pu_b & b_ext);
    rd_b = (m_dir_b & m_lat_b) | (~m_dir_b & lv_b);
  endtask

  task automatic check_all;
    predict();
    cmp({2'b00, a_oe}, oe_a, 8'hff);
    cmp({2'b00, a_pu}, pu_a, 8'hff);
    cmp({2'b00, a_out}, out_a, 8'h3b);
    cmp(b_oe, m_dir_b, 8'hff);
    cmp(b_pu, pu_b, 8'hff);
    cmp(b_out, m_lat_b, 8'hff);
    cmp({2'b00, kbi_pin}, kb_a, km_a);
    cmp({7'h00, irq_lvl}, {7'h00, lv_a[2] | ~irq_en},
        {7'h00, mk_a[2] | ~irq_en});
    rd_chk(GPX_OFS_A_DATA, rd_a, rm_a);
    rd_chk(GPX_OFS_B_DATA, rd_b, m_dir_b | mk_b);
    rd_chk(GPX_OFS_A_DIR, m_dir_a, 8'hff);
    rd_chk(GPX_OFS_B_DIR, m_dir_b, 8'hff);
    rd_chk(GPX_OFS_A_PUE, {m_sel, 1'b0, m_pue_a[5:0]}, 8'hff);
    rd_chk(GPX_OFS_B_PUE, m_pue_b, 8'hff);
    rd_chk(8'h02, 8'h00, 8'hff);
  endtask

  // reset driven low after one rising edge, seen low at the next, released right after it
  task automatic do_reset;
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    cmp({2'b00, a_oe}, 8'h00, 8'hff);
    cmp(b_oe, 8'h00, 8'hff);
    resetn <= 1'b1;
    m_dir_a = 8'h00;
    m_dir_b = 8'h00;
    m_pue_a = 8'h00;
    m_pue_b = 8'h00;
    m_sel = 1'b0;
  endtask

  task automatic conclude;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end

  initial begin
    do_reset();
    wr_reg(GPX_OFS_A_DATA, 8'h15);
    wr_reg(GPX_OFS_B_DATA, 8'ha6);
    repeat (3) @(posedge sys_clk);
    #1 check_all();
    for (int i = 0; i < 48; i++) begin
      @(posedge sys_clk);
      r = rnd();
      irq_en <= r[0];
      osc_int <= r[1];
      clk_x4 <= r[2];
      awake <= r[3];
      r = rnd();
      kbi_en <= r[5:0];
      r = rnd();
      a_ext <= r[5:0];
      r = rnd();
      a_en <= r[5:0];
      r = rnd();
      b_ext <= r;
      r = rnd();
      b_en <= r;
      for (int k = 0; k < 7; k++) begin
        r = rnd();
        wr_reg(ofs[k], r);
      end
      repeat (3) @(posedge sys_clk);
      #1 check_all();
      if (i == 30) begin
        do_reset();
        repeat (3) @(posedge sys_clk);
        #1 check_all();
      end
    end
    conclude();
  end
endmodule
